// File: design/tws_slave.sv
// two-wire serial register slave, 16-bit register address
// assumes the master drives the clock line; pins come from outside
`include "tws_map.svh"

module tws_slave #(
  parameter logic [6:0] DEV_ADDR = `TWS_DEV_ADDR,
  parameter int MEM_AW = `TWS_MEM_AW
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic serial_clock_in,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe_out,
  output tws_pkg::tws_state_t state_out
);
  import tws_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] scl_sync_r, sda_sync_r;
  logic scl_d_r, sda_d_r;
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], serial_clock_in};
      sda_sync_r <= {sda_sync_r[0], serial_data_line_in};
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
    end
  end
  wire scl = scl_sync_r[1];
  wire sda = sda_sync_r[1];
  wire scl_rise = scl & ~scl_d_r;
  wire scl_fall = ~scl & scl_d_r;
  wire start_cond = scl & scl_d_r & sda_d_r & ~sda;
  wire stop_cond = scl & scl_d_r & ~sda_d_r & sda;

  // ****************************************
  // byte engine
  // ****************************************
  tws_state_t state_r, state_nxt;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic ack_ph_r;
  logic [`TWS_REG_AW-1:0] ptr_r;
  logic drv_r, sdo_r;
  logic pull_r;
  logic ack_own_r;
  logic [7:0] rd_data;
  logic wr_en_r;

  wire byte_done = scl_rise & ~ack_ph_r & (bit_r == 4'h7);
  wire [7:0] byte_in = {sh_r[6:0], sda};
  wire addr_hit = byte_in[7:1] == DEV_ADDR;
  wire is_read = byte_in[0] == `TWS_DIR_READ;
  wire mst_nack = scl_rise & ack_ph_r & ~ack_own_r & sda;

  function automatic logic recv_state(input tws_state_t s);
    recv_state = (s == TWS_DEVA) | (s == TWS_ADHI) |
                 (s == TWS_ADLO) | (s == TWS_WDAT);
  endfunction : recv_state

  // our ack only for bytes we take in, never for a foreign address
  wire ack_due = recv_state(state_r) &
                 ~(state_r == TWS_DEVA & ~addr_hit);

  always_comb
  begin
    state_nxt = state_r;
    if (stop_cond)
      state_nxt = TWS_IDLE;
    else if (start_cond)
      state_nxt = TWS_DEVA;
    else if (byte_done)
    begin
      unique case (state_r)
        TWS_DEVA: state_nxt = !addr_hit ? TWS_SKIP :
                              (is_read ? TWS_RDAT : TWS_ADHI);
        TWS_ADHI: state_nxt = TWS_ADLO;
        TWS_ADLO: state_nxt = TWS_WDAT;
        default: state_nxt = state_r;
      endcase
    end
    else if (state_r == TWS_RDAT && mst_nack)
      state_nxt = TWS_SKIP;
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_r <= TWS_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ack_ph_r <= 1'b0;
      ptr_r <= 16'h0000;
      wr_en_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      wr_en_r <= 1'b0;
      if (start_cond | stop_cond)
      begin
        bit_r <= 4'h0;
        ack_ph_r <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (ack_ph_r)
        begin
          ack_ph_r <= 1'b0;
          bit_r <= 4'h0;
        end
        else
        begin
          sh_r <= byte_in;
          bit_r <= bit_r + 4'h1;
          ack_ph_r <= (bit_r == 4'h7);
        end
        if (byte_done && state_r == TWS_ADHI)
          ptr_r[15:8] <= byte_in;
        if (byte_done && state_r == TWS_ADLO)
          ptr_r[7:0] <= byte_in;
        if (byte_done && state_r == TWS_WDAT)
          wr_en_r <= 1'b1;
        if (state_r == TWS_RDAT && ack_ph_r && !ack_own_r)
          ptr_r <= ptr_r + 16'h0001;
      end
      if (wr_en_r)
        ptr_r <= ptr_r + 16'h0001;
    end
  end

  // ****************************************
  // data line driver, driven on falling clock, released at once on start, stop, skip or idle
  // ****************************************
  // ack_own_r marks an ack that is ours; the read address ack comes
  // when the state already says read, so state alone cannot tell
  logic [7:0] tx_r;
  wire quiet = start_cond | stop_cond | state_r == TWS_SKIP |
               state_r == TWS_IDLE;
  // first bit takes fresh memory word, later bits shift
  wire first_bit = bit_r == 4'h0;
  wire tx_bit = first_bit ? rd_data[7] : tx_r[7];
  wire [7:0] tx_nxt = first_bit ? {rd_data[6:0], 1'b0} :
                      {tx_r[6:0], 1'b0};
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      drv_r <= 1'b0;
      sdo_r <= 1'b1;
      pull_r <= 1'b0;
      ack_own_r <= 1'b0;
      tx_r <= 8'h00;
    end
    else if (quiet)
    begin
      drv_r <= 1'b0;
      pull_r <= 1'b0;
      ack_own_r <= 1'b0;
    end
    else if (byte_done)
      ack_own_r <= ack_due;
    else if (scl_fall)
    begin
      if (ack_ph_r && ack_own_r)
      begin
        drv_r <= 1'b1;
        sdo_r <= 1'b0;
        pull_r <= 1'b1;
      end
      else if (state_r == TWS_RDAT && !ack_ph_r)
      begin
        drv_r <= 1'b1;
        sdo_r <= tx_bit;
        pull_r <= ~tx_bit;
        tx_r <= tx_nxt;
      end
      else
      begin
        // master acks read bytes
        drv_r <= 1'b0;
        pull_r <= 1'b0;
      end
    end
  end

  assign serial_data_line_out = sdo_r;
  assign serial_data_line_oe_out = pull_r;
  assign state_out = state_r;

  // ****************************************
  // register storage
  // ****************************************
  tws_regmem #(.AW(MEM_AW)) u_mem (
    .ref_clk_in(ref_clk_in),
    .wr_en_in(wr_en_r),
    .addr_in(ptr_r[MEM_AW-1:0]),
    .wr_data_in(sh_r),
    .rd_data_out(rd_data)
  );

  // ****************************************
  // checks
  // ****************************************
  chk_foreign_quiet: assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) state_r == TWS_SKIP |=> !serial_data_line_oe_out)
    else $error("driving line while ignoring transfer");
  chk_nack_release: assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) (state_r == TWS_RDAT && mst_nack) |=> ##1 !drv_r)
    else $error("line held after master nack");
  chk_write_step: assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) wr_en_r |=> ptr_r == $past(ptr_r) + 16'h0001)
    else $error("pointer did not advance after write");
  chk_addr_hi: assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) (byte_done && state_r == TWS_ADHI && !stop_cond
    && !start_cond) |=> ptr_r[15:8] == $past(byte_in) && state_r == TWS_ADLO)
    else $error("high address byte not taken");
  chk_dir_read: assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) (byte_done && state_r == TWS_DEVA && addr_hit
    && is_read && !stop_cond && !start_cond) |=> state_r == TWS_RDAT)
    else $error("read direction not honoured");
  chk_write_store: assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) (byte_done && state_r == TWS_WDAT && !stop_cond
    && !start_cond) |=> wr_en_r)
    else $error("data byte not stored");
  chk_start_resets: assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) start_cond && !stop_cond |=> state_r == TWS_DEVA)
    else $error("start did not open address phase");
  chk_ack_low: assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) (scl_fall && ack_ph_r && recv_state(state_r)
    && !start_cond && !stop_cond) |=> serial_data_line_oe_out)
    else $error("no acknowledge driven");
endmodule : tws_slave

// File: include/tws_map.svh
// constants for the two-wire register slave
// assumes inclusion by the package and the slave design file
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH
`define TWS_DEV_ADDR 7'h10
`define TWS_REG_AW 16
`define TWS_MEM_AW 8
`define TWS_BITS_PER_BYTE 4'h8
`define TWS_DIR_READ 1'b1
`define TWS_DIR_WRITE 1'b0
`endif

// File: include/tws_pkg.sv
// types for the two-wire register slave
// assumes tws_map.svh on the include path
`include "tws_map.svh"
package tws_pkg;
  typedef enum logic [6:0] {
    TWS_IDLE = 7'h01,
    TWS_DEVA = 7'h02,
    TWS_ADHI = 7'h04,
    TWS_ADLO = 7'h08,
    TWS_WDAT = 7'h10,
    TWS_RDAT = 7'h20,
    TWS_SKIP = 7'h40
  } tws_state_t;
endpackage : tws_pkg

// File: design/tws_regmem.sv
// register storage behind the two-wire slave
// assumes one clock, single write port, registered read
module tws_regmem #(
  parameter int AW = 8
) (
  input wire logic ref_clk_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem_r [0:(1<<AW)-1];

  always_ff @(posedge ref_clk_in)
  begin
    if (wr_en_in)
    begin
      mem_r[addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_r[addr_in];
  end
endmodule : tws_regmem

// File: verification/tws_master.sv
// host-side bus master model for the two-wire register slave
// assumes a pull-up on the data wire; bit period 200 ns
module tws_master (
  output logic scl_out,
  output logic sda_low_out,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock stands high between frames, data released to the pull-up
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    #50 sda_low_out = ~b;
    #50 scl_out = 1'b1;
    #75 r = sda_in;
    #25 scl_out = 1'b0;
  endtask : bit_io
  // also serves as restart when the clock is low
  task automatic start;
    #50 sda_low_out = 1'b0;
    #50 scl_out = 1'b1;
    #75 sda_low_out = 1'b1;
    #75 scl_out = 1'b0;
  endtask : start
  task automatic stop;
    #50 sda_low_out = 1'b1;
    #50 scl_out = 1'b1;
    #75 sda_low_out = 1'b0;
    #100;
  endtask : stop
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : put
  task automatic get(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask : get
endmodule : tws_master

// File: verification/two_wire_register_slave_tb.sv
// self-checking bench for the two-wire register slave
// assumes the master model drives the link; reference memory in the bench
`include "tws_map.svh"
module two_wire_register_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tws_pkg::*;
  logic ref_clk_in;
  logic rst_b_in;
  logic scl;
  logic m_low;
  logic d_out;
  logic d_oe;
  tws_state_t st;
  wire sda = ~(m_low | d_oe);
  int miscompares = 0;
  int tests_run = 0;
  int seed = 32'hfc3d;
  int mem [256];
  int ptr;
  logic [7:0] dv;
  logic ak;
  tws_slave u_dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .serial_clock_in(scl), .serial_data_line_in(sda),
    .serial_data_line_out(d_out), .serial_data_line_oe_out(d_oe),
    .state_out(st));
  tws_master u_mst (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda));
  initial
  begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // n of zero leaves the frame open for a restart
  task automatic wr_seq(input logic [15:0] a, input int n);
    u_mst.start();
    u_mst.put({`TWS_DEV_ADDR, `TWS_DIR_WRITE}, ak);
    chk({7'h0, ak}, 8'h01);
    u_mst.put(a[15:8], ak);
    chk({7'h0, ak}, 8'h01);
    u_mst.put(a[7:0], ak);
    chk({7'h0, ak}, 8'h01);
    ptr = int'(a[7:0]);
    for (int i = 0; i < n; i++)
    begin
      dv = 8'($random(seed));
      u_mst.put(dv, ak);
      chk({7'h0, ak}, 8'h01);
      mem[ptr] = int'(dv);
      ptr = (ptr + 1) % 256;
    end
  endtask : wr_seq
  task automatic rd_seq(input int n);
    u_mst.start();
    u_mst.put({`TWS_DEV_ADDR, `TWS_DIR_READ}, ak);
    chk({7'h0, ak}, 8'h01);
    for (int i = 0; i < n; i++)
    begin
      u_mst.get(dv, i < n - 1);
      chk(dv, mem[ptr][7:0]);
      ptr = (ptr + 1) % 256;
    end
    u_mst.stop();
    chk({7'h0, d_oe}, 8'h00);
    chk({7'h0, d_out}, {7'h0, mem[(ptr + 255) % 256][0]});
  endtask : rd_seq
  // ******************************
  // scenarios
  // ******************************
  initial
  begin
    rst_b_in = 1'b0;
    repeat (4) @(posedge ref_clk_in);
    #1 rst_b_in = 1'b1;
    chk(8'(st), 8'(TWS_IDLE));
    repeat (3) @(posedge ref_clk_in);
    #1;
    wr_seq(16'h1234, 1);
    u_mst.stop();
    $display("single write done");
    // pointer wraps across the low byte
    wr_seq(16'h21FE, 4);
    u_mst.stop();
    $display("sequential write done");
    wr_seq(16'h21FE, 0);
    rd_seq(3);
    rd_seq(1);
    $display("random and current reads done");
    // foreign address must stay silent and store nothing
    u_mst.start();
    u_mst.put({`TWS_DEV_ADDR ^ 7'h05, `TWS_DIR_WRITE}, ak);
    chk({7'h0, ak}, 8'h00);
    u_mst.put(8'h12, ak);
    chk({7'h0, ak}, 8'h00);
    u_mst.put(8'h34, ak);
    u_mst.put(~mem[8'h34][7:0], ak);
    chk({7'h0, d_oe}, 8'h00);
    u_mst.stop();
    wr_seq(16'h1234, 0);
    rd_seq(1);
    $display("foreign address done");
    complete_run();
  end
  initial
  begin
    #1000000;
    miscompares++;
    complete_run();
  end
endmodule : two_wire_register_slave_tb
